// ==== fia_pkg.sv ====
// constants, register map and types of the flash programming sequencer
package fia_pkg;
    // widths
    localparam int ADDR_W = 14;
    localparam int BUS_AW = 9;
    localparam int TMR_W = 18;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h50;
    localparam logic [7:0] IDX_BUF_CLEAR = 8'h52;
    localparam logic [7:0] IDX_ADDR_LOW = 8'h53;
    localparam logic [7:0] IDX_ADDR_HIGH = 8'h54;
    localparam logic [7:0] IDX_DATA0 = 8'h55;
    localparam int DATA_REGS = 8;
    // control register fields
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_RDEN = 3;
    localparam int CTRL_ARM = 4;
    localparam int CTRL_GO = 5;
    localparam int CTRL_RDGO = 6;
    localparam int CTRL_UNLOCKED = 7;
    localparam int CLEAR_BIT = 0;
    // operation select codes
    localparam logic [2:0] OP_WRITE = 3'h0;
    localparam logic [2:0] OP_ERASE = 3'h1;
    localparam logic [2:0] OP_READ = 3'h3;
    localparam logic [2:0] OP_UNLOCK = 3'h6;
    // array geometry
    localparam int BLOCK_SHIFT = 8;
    localparam int PAGE_SHIFT = 6;
    localparam logic [6:0] PAGE_WORDS = 7'h40;
    localparam logic [6:0] BLOCK_PROG_WORDS = 7'h04;
    localparam logic [5:0] PAGE_LAST = 6'h3F;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_TIME_NS = 2200000;
    localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int READ_INSTR_CYCLES = 3;
    localparam int CLKS_PER_INSTR = 4;
    localparam int READ_CYCLES = READ_INSTR_CYCLES * CLKS_PER_INSTR;
    localparam logic [8:0] UNLOCK_WINDOW_CYC = 9'h100;
    // unlock pattern, lowest byte is the second word low register
    localparam logic [47:0] UNLOCK_PATTERN = 48'h40C3090D0400;
    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;

    typedef enum logic [1:0] {
        FIA_IDLE, FIA_ERASE, FIA_PROG, FIA_READ
    } fia_state_t;

    function automatic logic [BUS_AW-1:0] fia_reg_addr(logic [7:0] idx);
        return {idx[6:0], 2'b00};
    endfunction : fia_reg_addr
endpackage : fia_pkg

// ==== fia_tmr_if.sv ====
// start and completion signals between sequencer and its operation timer
`timescale 1ns/10ps
interface fia_tmr_if;
    logic start;
    logic [fia_pkg::TMR_W-1:0] loadVal;
    logic done;
    modport owner(output start, output loadVal, input done);
    modport timer(input start, input loadVal, output done);
endinterface : fia_tmr_if

// ==== fia_op_timer.sv ====
// down counter that times erase, program and read operations
`timescale 1ns/10ps
module fia_op_timer (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control
    fia_tmr_if.timer tmr
);
    import fia_pkg::*;

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic done;
    } fia_tmr_st_t;

    fia_tmr_st_t cur_q;
    fia_tmr_st_t cur_d;

    always_comb begin
        cur_d = cur_q;
        cur_d.done = 1'b0;
        if (tmr.start) begin
            cur_d.cnt = tmr.loadVal;
        end else if (cur_q.cnt != '0) begin
            cur_d.cnt = cur_q.cnt - TMR_W'(1);
            cur_d.done = (cur_q.cnt == {{(TMR_W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cur_q <= '0;
        end else begin
            cur_q <= cur_d;
        end
    end

    assign tmr.done = cur_q.done;

    a_timer_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        cur_q.cnt == '0 && !tmr.start |=> !tmr.done) // R11
        else $error("timer fired while idle");
endmodule : fia_op_timer

// ==== fia_unlock_check.sv ====
// unlock window and pattern check for erase and write access
`timescale 1ns/10ps
module fia_unlock_check (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // arm request and pattern bytes
    input wire logic armStart,
    input wire logic [5:0][7:0] patternBytes,
    // window state and result
    output logic unlockArm,
    output logic unlockPass
);
    import fia_pkg::*;

    typedef struct packed {
        logic [8:0] cnt;
        logic armed;
        logic pass;
    } fia_unl_st_t;

    fia_unl_st_t cur_q;
    fia_unl_st_t cur_d;

    always_comb begin
        cur_d = cur_q;
        cur_d.pass = 1'b0;
        if (armStart && !cur_q.armed) begin
            cur_d.armed = 1'b1; // R21
            cur_d.cnt = UNLOCK_WINDOW_CYC;
        end else if (cur_q.armed) begin
            cur_d.cnt = cur_q.cnt - 9'h001;
            if (cur_q.cnt == 9'h001) begin
                cur_d.armed = 1'b0; // R21
                cur_d.pass = (patternBytes == UNLOCK_PATTERN); // R21
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cur_q <= '0;
        end else begin
            cur_q <= cur_d;
        end
    end

    assign unlockArm = cur_q.armed;
    assign unlockPass = cur_q.pass;

    a_arm_timeout: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(cur_q.armed) |-> ##[1:300] !cur_q.armed) // R21
        else $error("unlock window never closed");
    a_pass_at_end: assert property (@(posedge clk) disable iff (!reset_n)
        cur_q.pass |-> $fell(cur_q.armed)) // R21
        else $error("unlock pass outside window end");
endmodule : fia_unlock_check

// ==== fia_sequencer.sv ====
// flash programming sequencer with its register slave
// Notes on behaviour
// R1 - software unlocks before any erase or write
// R2 - block erase unit: 256 words, bits 11-8; the code takes the block from address bits 13-8
// R3 - page buffer 64 words, page bits 13-6
// R4 - block program: four words, low bits ignored
// R5 - high byte load pushes word, address advances
// R6 - buffer address stops at last page word
// R7 - select 001 plus go erases unit
// R8 - select 000 plus go programs buffer
// R9 - block program: four registers from offset zero
// R10 - cpu stalled while erase or program runs
// R11 - go bit stays high 2.2 ms
// R12 - software keeps buffer page equal address page
// R13 - page program never leaves its page
// R14 - page reprogram allowed without erase
// R15 - block retry needs fresh erase first
// R16 - read: select 011, enable, go, data
// R17 - reads need no unlock
// R18 - software reloads address between scattered words
// R19 - clearing unlocked flag refuses erase, write
// R20 - software runs fast clock while programming
// R21 - unlock: select 110, arm, six-byte pattern
// R22 - buffer clear bit self-clears when done
// R23 - low byte write stays in register
// R24 - read go falls after three instruction cycles
// R25 - go while locked: no change, clears
// R26 - go bits read high while busy; the code holds reads off until the operation ends, so they read low
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
module fia_sequencer #(
    parameter int PROG_CYCLES = fia_pkg::PROG_CYCLES,
    parameter bit PAGE_VARIANT = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // avalon-mm slave
    input wire logic [fia_pkg::BUS_AW-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // flash array
    output logic flashEraseStb,
    output logic flashProgStb,
    output logic flashReadStb,
    output logic [fia_pkg::ADDR_W-1:0] flashArrAddr,
    output logic [15:0] flashArrWdata,
    input wire logic [15:0] flashArrRdata,
    // cpu
    output logic cpuStall
);
    import fia_pkg::*;

    typedef struct packed {
        fia_state_t st;
        logic [2:0] flashOpSelect;
        logic readFunctionEnable;
        logic programEraseGo;
        logic readGo;
        logic eraseWriteUnlocked;
        logic bufferClearGo;
        logic [ADDR_W-1:0] flashAddr;
        logic [DATA_REGS-1:0][7:0] dataBytes;
        logic [63:0][15:0] wbuf;
        logic [6:0] progIdx;
        logic waitQ;
        logic [31:0] rdata;
        logic eraseStb;
        logic progStb;
        logic readStb;
        logic [ADDR_W-1:0] arrAddr;
        logic [15:0] arrData;
        logic stall;
    } fia_top_st_t;

    fia_top_st_t cur_q;
    fia_top_st_t cur_d;
    fia_tmr_if tmrBus();
    logic tmrStart;
    logic [TMR_W-1:0] tmrLoad;
    logic unlockArm;
    logic unlockPass;
    logic armStart;
    logic busy;
    logic wrHit;
    logic wrCtrl;
    logic [6:0] progWords;

    function automatic logic regHit(logic [BUS_AW-1:0] a, logic [7:0] idx);
        return a == fia_reg_addr(idx);
    endfunction : regHit

    function automatic logic [ADDR_W-1:0] unitBase(logic [ADDR_W-1:0] a);
        if (PAGE_VARIANT) begin
            return {a[ADDR_W-1:PAGE_SHIFT], {PAGE_SHIFT{1'b0}}};
        end
        return {a[ADDR_W-1:BLOCK_SHIFT], {BLOCK_SHIFT{1'b0}}};
    endfunction : unitBase

    fia_op_timer u_timer (
        .clk(clk),
        .reset_n(reset_n),
        .tmr(tmrBus.timer)
    );

    fia_unlock_check u_unlock (
        .clk(clk),
        .reset_n(reset_n),
        .armStart(armStart),
        .patternBytes(cur_q.dataBytes[7:2]),
        .unlockArm(unlockArm),
        .unlockPass(unlockPass)
    );

    assign tmrBus.start = tmrStart;
    assign tmrBus.loadVal = tmrLoad;
    assign busy = (cur_q.st != FIA_IDLE) || cur_q.bufferClearGo;
    assign wrHit = write && !cur_q.waitQ;
    assign wrCtrl = wrHit && regHit(address, IDX_CTRL);
    assign progWords = PAGE_VARIANT ? PAGE_WORDS : BLOCK_PROG_WORDS;

    always_comb begin
        logic [7:0] rd;
        logic [1:0] w;
        rd = 8'h00;
        w = cur_q.progIdx[1:0];
        cur_d = cur_q;
        tmrStart = 1'b0;
        tmrLoad = '0;
        armStart = 1'b0;
        cur_d.eraseStb = 1'b0;
        cur_d.progStb = 1'b0;
        cur_d.readStb = 1'b0;
        // register read mux
        if (regHit(address, IDX_CTRL)) begin
            rd = {cur_q.eraseWriteUnlocked, cur_q.readGo,
                cur_q.programEraseGo, unlockArm,
                cur_q.readFunctionEnable, cur_q.flashOpSelect}; // R26
        end else if (regHit(address, IDX_BUF_CLEAR)) begin
            rd = {7'h00, cur_q.bufferClearGo};
        end else if (regHit(address, IDX_ADDR_LOW)) begin
            rd = cur_q.flashAddr[7:0];
        end else if (regHit(address, IDX_ADDR_HIGH)) begin
            rd = {2'b00, cur_q.flashAddr[ADDR_W-1:8]};
        end
        for (int k = 0; k < DATA_REGS; k++) begin
            if (regHit(address, 8'(int'(IDX_DATA0) + k))) begin
                rd = cur_q.dataBytes[k];
            end
        end
        // bus handshake, held off while the cpu is stalled
        cur_d.waitQ = 1'b1;
        if ((read || write) && cur_q.waitQ && !busy) begin
            cur_d.waitQ = 1'b0; // R10
            cur_d.rdata = {24'h000000, rd};
        end
        // control register
        if (wrCtrl) begin
            cur_d.flashOpSelect = writedata[CTRL_OP_LSB +: 3];
            cur_d.readFunctionEnable = writedata[CTRL_RDEN];
            if (!writedata[CTRL_UNLOCKED]) begin
                cur_d.eraseWriteUnlocked = 1'b0; // R19
            end
            armStart = writedata[CTRL_ARM]
                && writedata[CTRL_OP_LSB +: 3] == OP_UNLOCK; // R21
            if (writedata[CTRL_GO] && cur_q.eraseWriteUnlocked
                && writedata[CTRL_UNLOCKED]) begin // R25
                if (writedata[CTRL_OP_LSB +: 3] == OP_ERASE) begin
                    cur_d.programEraseGo = 1'b1; // R7
                    cur_d.st = FIA_ERASE;
                    cur_d.eraseStb = 1'b1;
                    cur_d.arrAddr = unitBase(cur_q.flashAddr); // R2 R3
                    tmrStart = 1'b1;
                    tmrLoad = TMR_W'(PROG_CYCLES); // R11
                end else if (writedata[CTRL_OP_LSB +: 3] == OP_WRITE) begin
                    cur_d.programEraseGo = 1'b1; // R8 R14
                    cur_d.st = FIA_PROG;
                    cur_d.progIdx = 7'h00;
                    tmrStart = 1'b1;
                    tmrLoad = TMR_W'(PROG_CYCLES); // R11
                end
            end else if (writedata[CTRL_RDGO]
                && writedata[CTRL_RDEN]
                && writedata[CTRL_OP_LSB +: 3] == OP_READ) begin
                cur_d.readGo = 1'b1; // R16 R17
                cur_d.st = FIA_READ;
                cur_d.readStb = 1'b1;
                cur_d.arrAddr = cur_q.flashAddr;
                tmrStart = 1'b1;
                tmrLoad = TMR_W'(READ_CYCLES); // R24
            end
        end
        // set wins over a clear in the same cycle
        if (unlockPass) begin
            cur_d.eraseWriteUnlocked = 1'b1; // R21
        end
        // address, data and buffer registers
        if (wrHit && regHit(address, IDX_ADDR_LOW)) begin
            cur_d.flashAddr[7:0] = writedata[7:0];
        end
        if (wrHit && regHit(address, IDX_ADDR_HIGH)) begin
            cur_d.flashAddr[ADDR_W-1:8] = writedata[ADDR_W-9:0];
        end
        for (int k = 0; k < DATA_REGS; k++) begin
            if (wrHit && regHit(address, 8'(int'(IDX_DATA0) + k))) begin
                cur_d.dataBytes[k] = writedata[7:0]; // R23
            end
        end
        if (PAGE_VARIANT && wrHit
            && regHit(address, 8'(int'(IDX_DATA0) + 1))) begin
            cur_d.wbuf[cur_q.flashAddr[PAGE_SHIFT-1:0]] =
                {writedata[7:0], cur_q.dataBytes[0]}; // R5
            if (cur_q.flashAddr[PAGE_SHIFT-1:0] != PAGE_LAST) begin
                cur_d.flashAddr = cur_q.flashAddr + 14'h0001; // R5
            end // R6
        end
        if (PAGE_VARIANT && wrHit && regHit(address, IDX_BUF_CLEAR)
            && writedata[CLEAR_BIT]) begin
            cur_d.bufferClearGo = 1'b1; // R22
        end
        if (cur_q.bufferClearGo) begin
            cur_d.wbuf = '0;
            cur_d.bufferClearGo = 1'b0; // R22
        end
        // operation sequencing
        case (cur_q.st)
            FIA_IDLE: begin
            end
            FIA_ERASE: begin
                if (tmrBus.done) begin
                    cur_d.programEraseGo = 1'b0; // R7
                    cur_d.st = FIA_IDLE;
                end
            end
            FIA_PROG: begin
                if (cur_q.progIdx < progWords) begin
                    cur_d.progStb = 1'b1;
                    cur_d.progIdx = cur_q.progIdx + 7'h01;
                    if (PAGE_VARIANT) begin
                        cur_d.arrAddr = {cur_q.flashAddr[ADDR_W-1:PAGE_SHIFT],
                            cur_q.progIdx[PAGE_SHIFT-1:0]}; // R13
                        cur_d.arrData =
                            cur_q.wbuf[cur_q.progIdx[PAGE_SHIFT-1:0]]; // R8
                    end else begin
                        cur_d.arrAddr = {cur_q.flashAddr[ADDR_W-1:2], w}; // R4
                        cur_d.arrData = {cur_q.dataBytes[{w, 1'b1}],
                            cur_q.dataBytes[{w, 1'b0}]}; // R9
                    end
                end
                if (tmrBus.done) begin
                    cur_d.programEraseGo = 1'b0; // R8
                    cur_d.st = FIA_IDLE;
                end
            end
            FIA_READ: begin
                if (tmrBus.done) begin
                    cur_d.dataBytes[0] = flashArrRdata[7:0]; // R16
                    cur_d.dataBytes[1] = flashArrRdata[15:8];
                    cur_d.readGo = 1'b0; // R24
                    cur_d.st = FIA_IDLE;
                end
            end
            default: begin
                cur_d.st = FIA_IDLE;
            end
        endcase
        cur_d.stall = (cur_d.st != FIA_IDLE); // R10
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cur_q <= '0;
            cur_q.st <= FIA_IDLE;
            cur_q.flashAddr <= ADDR_RST;
            cur_q.waitQ <= 1'b1;
        end else begin
            cur_q <= cur_d;
        end
    end

    assign readdata = cur_q.rdata;
    assign waitrequest = cur_q.waitQ;
    assign flashEraseStb = cur_q.eraseStb;
    assign flashProgStb = cur_q.progStb;
    assign flashReadStb = cur_q.readStb;
    assign flashArrAddr = cur_q.arrAddr;
    assign flashArrWdata = cur_q.arrData;
    assign cpuStall = cur_q.stall;

    // checking helpers
    localparam int GO_LEN = PROG_CYCLES + 1;
    logic [19:0] goLen;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            goLen <= 20'h00000;
        end else begin
            goLen <= cur_q.programEraseGo ? goLen + 20'h00001 : 20'h00000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_go_locked: assert property ( // R25
        wrCtrl && writedata[CTRL_GO] && !cur_q.eraseWriteUnlocked
        |=> !cur_q.programEraseGo && !flashEraseStb && !flashProgStb)
        else $error("erase or write started while locked");
    a_stall_busy: assert property ( // R10
        $rose(cur_q.programEraseGo) |-> cpuStall && waitrequest)
        else $error("cpu not stalled during operation");
    a_go_length: assert property ( // R11
        $fell(cur_q.programEraseGo) |-> goLen == GO_LEN)
        else $error("go bit held wrong length");
    a_page_incr: assert property ( // R5
        PAGE_VARIANT && wrHit && regHit(address, IDX_DATA0 + 8'h01)
        && cur_q.flashAddr[5:0] != PAGE_LAST
        |=> cur_q.flashAddr == $past(cur_q.flashAddr) + 14'h0001)
        else $error("buffer address did not advance");
    a_page_hold: assert property ( // R6
        PAGE_VARIANT && wrHit && regHit(address, IDX_DATA0 + 8'h01)
        && cur_q.flashAddr[5:0] == PAGE_LAST |=> $stable(cur_q.flashAddr))
        else $error("buffer address passed page end");
    a_low_only: assert property ( // R23
        wrHit && regHit(address, IDX_DATA0) |=> $stable(cur_q.wbuf))
        else $error("low byte write reached buffer");
    a_erase_align: assert property ( // R2 R3 R7
        flashEraseStb |-> flashArrAddr == unitBase(cur_q.flashAddr))
        else $error("erase address not unit aligned");
    a_prog_bound: assert property ( // R4 R9 R13
        flashProgStb |-> (PAGE_VARIANT
        ? flashArrAddr[13:6] == cur_q.flashAddr[13:6]
        : flashArrAddr[13:2] == cur_q.flashAddr[13:2]))
        else $error("program left its unit");
    a_read_data: assert property ( // R16
        $fell(cur_q.readGo) |-> cur_q.dataBytes[1:0] == $past(flashArrRdata))
        else $error("read word not presented");
    a_read_time: assert property ( // R24
        $rose(cur_q.readGo) |-> ##[12:14] !cur_q.readGo)
        else $error("read go bit wrong length");
    a_clear_done: assert property ( // R22
        $rose(cur_q.bufferClearGo) |=> !cur_q.bufferClearGo
        && cur_q.wbuf == '0)
        else $error("buffer clear incomplete");

    c_erase_done: cover property (
        $fell(cur_q.programEraseGo) && $past(cur_q.st) == FIA_ERASE);
    c_prog_done: cover property (
        $fell(cur_q.programEraseGo) && $past(cur_q.st) == FIA_PROG);
    c_read_done: cover property ($fell(cur_q.readGo));
    c_unlocked: cover property ($rose(cur_q.eraseWriteUnlocked));
endmodule : fia_sequencer

// ==== fia_flash_model.sv ====
// behavioural program flash array facing the sequencer
`timescale 1ns/10ps
module fia_flash_model #(
    parameter bit PAGE_VARIANT = 1'b1
) (
    // clock
    input wire logic clk,
    // array strobes and data
    input wire logic eraseStb,
    input wire logic progStb,
    input wire logic readStb,
    input wire logic [fia_pkg::ADDR_W-1:0] arrAddr,
    input wire logic [15:0] arrWdata,
    output logic [15:0] arrRdata
);
    import fia_pkg::*;
    logic [15:0] mem [0:(1<<ADDR_W)-1];
    logic [15:0] lastQ = 16'h0000;
    int holdCnt = 0;
    int unitWords;
    int base;
    assign unitWords = PAGE_VARIANT ? 64 : 256;
    assign base = int'(arrAddr) & ~(unitWords - 1);
    // data stands only while the read is running, then turns over
    assign arrRdata = (holdCnt > 0) ? lastQ : ~lastQ;
    always @(posedge clk) begin
        if (eraseStb) begin
            for (int i = 0; i < unitWords; i++) begin
                mem[base + i] = 16'h0000;
            end
        end
        if (progStb) begin
            mem[arrAddr] = arrWdata;
        end
        if (readStb) begin
            lastQ <= mem[arrAddr];
            holdCnt <= 13;
        end else if (holdCnt > 0) begin
            holdCnt <= holdCnt - 1;
        end
    end
endmodule : fia_flash_model

// ==== fia_sequencer_tb.sv ====
// randomised self-checking bench of the flash programming sequencer
`timescale 1ns/10ps
module fia_sequencer_tb;
    import fia_pkg::*;
    localparam int PROG_N = 100;
    logic clk = 1'b0;
    logic resetN = 1'b0;
    logic [BUS_AW-1:0] address = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic waitReq, eraseStb, progStb, readStb, cpuStall;
    logic [ADDR_W-1:0] arrAddr;
    logic [15:0] arrWdata, arrRdata;
    logic waitReqB, eraseB, progB, readB;
    logic [ADDR_W-1:0] addrB;
    logic [15:0] wdataB, rdataB;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0, eraseCnt = 0, progCnt = 0, stallRun = 0, stallLast = 0;
    logic [7:0] pg = 8'h00;
    fia_sequencer #(.PROG_CYCLES(PROG_N), .PAGE_VARIANT(1'b1)) dut (
        .clk(clk), .reset_n(resetN), .address(address), .read(rd),
        .write(wr), .writedata(wdata), .readdata(rdata),
        .waitrequest(waitReq), .flashEraseStb(eraseStb),
        .flashProgStb(progStb), .flashReadStb(readStb),
        .flashArrAddr(arrAddr), .flashArrWdata(arrWdata),
        .flashArrRdata(arrRdata), .cpuStall(cpuStall));
    fia_flash_model #(.PAGE_VARIANT(1'b1)) flash (
        .clk(clk), .eraseStb(eraseStb), .progStb(progStb),
        .readStb(readStb), .arrAddr(arrAddr), .arrWdata(arrWdata),
        .arrRdata(arrRdata));
    fia_sequencer #(.PROG_CYCLES(PROG_N), .PAGE_VARIANT(1'b0)) dutBlk (
        .clk(clk), .reset_n(resetN), .address(address), .read(rd),
        .write(wr), .writedata(wdata), .readdata(),
        .waitrequest(waitReqB), .flashEraseStb(eraseB),
        .flashProgStb(progB), .flashReadStb(readB),
        .flashArrAddr(addrB), .flashArrWdata(wdataB),
        .flashArrRdata(rdataB), .cpuStall());
    fia_flash_model #(.PAGE_VARIANT(1'b0)) flashB (
        .clk(clk), .eraseStb(eraseB), .progStb(progB),
        .readStb(readB), .arrAddr(addrB), .arrWdata(wdataB),
        .arrRdata(rdataB));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic test_done;
        $display("mismatches %0d, checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
            input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got,
                exp);
        end
    endtask : chk
    // one avalon access, held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [7:0] idx,
            input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk);
        address <= {idx[6:0], 2'b00};
        wr <= w;
        rd <= !w;
        wdata <= {24'h000000, d};
        do begin
            @(posedge clk);
            n++;
        end while (waitReq !== 1'b0 && n < 2000);
        q = rdata[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 2000) begin
            err_count++;
            test_done();
        end
    endtask : acc
    task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, idx, d, q);
    endtask : wreg
    task automatic setaddr(input logic [13:0] a);
        wreg(IDX_ADDR_LOW, a[7:0]);
        wreg(IDX_ADDR_HIGH, {2'b00, a[13:8]});
    endtask : setaddr
    always @(posedge clk) begin
        cyc++;
        eraseCnt += int'(eraseStb);
        progCnt += int'(progStb);
        if (progStb) chk({8'h00, arrAddr[13:6]}, {8'h00, pg}, "prog page");
        if (waitReqB !== waitReq) chk(waitReqB, waitReq, "lockstep");
        if (cpuStall === 1'b1) begin
            stallRun++;
        end else if (stallRun != 0) begin
            stallLast = stallRun;
            stallRun = 0;
        end
        if (cyc > 20000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        logic [7:0] q;
        logic [13:0] a;
        logic [15:0] w, keep;
        logic [15:0] exp [0:63];
        int n;
        void'($urandom(755));
        repeat (12) @(posedge clk);
        resetN <= 1'b1;
        acc(1'b0, IDX_CTRL, 8'h00, q);
        chk({8'h00, q}, 16'h0000, "ctrl reset");
        wreg(8'h51, 8'hFF);
        acc(1'b0, 8'h51, 8'h00, q);
        chk({8'h00, q}, 16'h0000, "unmapped");
        for (int i = 0; i < 4; i++) begin
            a = 14'($urandom);
            w = 16'($urandom);
            flash.mem[a] = w;
            flashB.mem[a] = w;
            setaddr(a);
            wreg(IDX_CTRL, 8'h4B);
            acc(1'b0, IDX_DATA0, 8'h00, q);
            w[7:0] = w[7:0] ^ q;
            acc(1'b0, IDX_DATA0 + 8'h01, 8'h00, q);
            chk({q, w[7:0]}, {w[15:8], 8'h00}, "read word");
        end
        n = eraseCnt;
        wreg(IDX_CTRL, 8'hA1);
        acc(1'b0, IDX_CTRL, 8'h00, q);
        chk({15'h0000, q[5]} | 16'(eraseCnt - n), 16'h0000, "locked go");
        for (int k = 0; k < 2; k++) begin
            wreg(IDX_CTRL, 8'h16);
            for (int i = 0; i < 6; i++) begin
                wreg(8'h57 + 8'(i), (i == 5) ? 8'h41 - 8'(k) :
                    8'({8'hC3, 8'h09, 8'h0D, 8'h04, 8'h00} >> (8 * i)));
            end
            n = 0;
            do begin
                acc(1'b0, IDX_CTRL, 8'h00, q);
                n++;
            end while (q[4] === 1'b1 && n < 400);
            acc(1'b0, IDX_CTRL, 8'h00, q);
            chk({15'h0000, q[7]}, 16'(k), "unlocked");
        end
        pg = 8'($urandom % 255);
        for (int i = 0; i < 65; i++) flash.mem[{pg, 6'h00} + i] = 16'($urandom);
        keep = flash.mem[{pg, 6'h00} + 64];
        flashB.mem[{pg[7:2], 8'hFF}] = 16'hFFFF;
        n = eraseCnt;
        setaddr({pg, 6'($urandom)});
        wreg(IDX_CTRL, 8'hA1);
        acc(1'b0, IDX_CTRL, 8'h00, q);
        chk({15'h0000, q[5]}, 16'h0000, "erase go clears");
        chk(16'(eraseCnt - n), 16'h0001, "erase strobes");
        chk(16'(stallLast >= PROG_N && stallLast <= PROG_N + 3), 16'h0001,
            "erase stall");
        for (int i = 0; i < 64; i++) chk(flash.mem[{pg, 6'h00} + i], 16'h0000, "blank");
        chk(flash.mem[{pg, 6'h00} + 64], keep, "next page");
        chk(flashB.mem[{pg[7:2], 8'hFF}], 16'h0000, "block blank");
        setaddr({pg, 6'h00});
        for (int i = 0; i < 66; i++) begin
            w = 16'($urandom);
            wreg(IDX_DATA0, ~w[7:0]);
            wreg(IDX_DATA0, w[7:0]);
            wreg(IDX_DATA0 + 8'h01, w[15:8]);
            exp[(i > 63) ? 63 : i] = w;
        end
        acc(1'b0, IDX_ADDR_LOW, 8'h00, q);
        chk({8'h00, q}, {8'h00, pg[1:0], 6'h3F}, "addr stops");
        n = progCnt;
        wreg(IDX_CTRL, 8'hA0);
        acc(1'b0, IDX_CTRL, 8'h00, q);
        chk(16'(progCnt - n), 16'h0040, "prog strobes");
        for (int i = 0; i < 64; i++) chk(flash.mem[{pg, 6'h00} + i], exp[i], "page");
        for (int i = 0; i < 4; i++) chk(flashB.mem[{pg, 6'h00} + i],
            (i == 0) ? exp[63] : UNLOCK_PATTERN[16 * i - 16 +: 16],
            "block word");
        wreg(IDX_BUF_CLEAR, 8'h01);
        acc(1'b0, IDX_BUF_CLEAR, 8'h00, q);
        chk({8'h00, q}, 16'h0000, "clear bit");
        w = 16'($urandom);
        setaddr({pg, 6'h05});
        wreg(IDX_DATA0, w[7:0]);
        wreg(IDX_DATA0 + 8'h01, w[15:8]);
        wreg(IDX_CTRL, 8'hA0);
        acc(1'b0, IDX_CTRL, 8'h00, q);
        chk(flash.mem[{pg, 6'h05}], w, "reprogram");
        chk(flash.mem[{pg, 6'h00}], 16'h0000, "cleared word");
        chk(flashB.mem[{pg, 6'h04}], w, "block unit");
        wreg(IDX_CTRL, 8'h00);
        n = eraseCnt;
        wreg(IDX_CTRL, 8'hA1);
        acc(1'b0, IDX_CTRL, 8'h00, q);
        chk({15'h0000, q[7]} | 16'(eraseCnt - n), 16'h0000, "relocked");
        test_done();
    end
endmodule : fia_sequencer_tb
